// file: hdl/vdc_ctrl.sv
// Controller that drives the strobe pins of a dual-port video DRAM.
// Assumes pin inputs synchronous to clock; software port never waits.
`timescale 1ns/1ps

// Contract
// - CAS low, select low at RAS fall: refresh resetting all options.
// - CAS low, write-enable low, select high: refresh loading stop code.
// - CAS low, write-enable high, select high: plain refresh only.
// - All high, select low at both edges: normal read or write.
// - Write-enable low, select low at both edges: masked write.
// - Select low at RAS, high at CAS: block write with column mask.
// - Write-enable low, select high at RAS: flash write of color.
// - Select high at RAS, enables high: load mask or color at CAS.
// - Transfer-enable low, write high, select low: read transfer.
// - As read transfer with select high: split read transfer.
// - Transfer and write low, select low: masked write transfer.
// - Same with select high: masked split write transfer.
// - Reset-all refresh restores per-cycle mask; mask each masked RAS. The code drives no mask at RAS while a loaded plane mask is held.
module vdc_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output vdc_pkg::vdc_ctl_t ctl,
	output logic [8:0] address_pins,
	output logic [7:0] dq_out,
	output logic [7:0] dq_oe,
	input wire logic [7:0] dq_in,
	input wire logic split_half_flag
);
	import vdc_pkg::*;

	// ------------------------------------------------------------
	// Decoding
	// ------------------------------------------------------------
	// Pin levels at the RAS fall for each command.
	function automatic vdc_ctl_t ras_levels(input vdc_cmd_t c);
		vdc_ctl_t v;
		v = '{ras_n: 1'b0, cas_n: 1'b1, transfer_output_enable_n: 1'b1,
			mask_write_enable_n: 1'b1, special_function_select: 1'b0};
		case (c)
			CMD_REFRESH_RESET_ALL: v.cas_n = 1'b0;
			CMD_REFRESH_SET_STOP:
			begin
				v.cas_n = 1'b0;
				v.mask_write_enable_n = 1'b0;
				v.special_function_select = 1'b1;
			end
			CMD_REFRESH_PLAIN:
			begin
				v.cas_n = 1'b0;
				v.special_function_select = 1'b1;
			end
			CMD_ROW_ONLY_REFRESH: v.cas_n = 1'b1;
			CMD_MASKED_ARRAY_WRITE, CMD_MASKED_BLOCK_WRITE:
				v.mask_write_enable_n = 1'b0;
			CMD_MASKED_FLASH_WRITE:
			begin
				v.mask_write_enable_n = 1'b0;
				v.special_function_select = 1'b1;
			end
			CMD_LOAD_PLANE_MASK, CMD_LOAD_FILL_COLOR:
				v.special_function_select = 1'b1;
			CMD_ROW_TO_BUFFER: v.transfer_output_enable_n = 1'b0;
			CMD_SPLIT_ROW_TO_BUFFER:
			begin
				v.transfer_output_enable_n = 1'b0;
				v.special_function_select = 1'b1;
			end
			CMD_MASKED_BUFFER_TO_ROW:
			begin
				v.transfer_output_enable_n = 1'b0;
				v.mask_write_enable_n = 1'b0;
			end
			CMD_MASKED_SPLIT_BUFFER_TO_ROW:
			begin
				v.transfer_output_enable_n = 1'b0;
				v.mask_write_enable_n = 1'b0;
				v.special_function_select = 1'b1;
			end
			default: v = v;
		endcase
		return v;
	endfunction : ras_levels

	function automatic logic is_cbr(input vdc_cmd_t c);
		return c == CMD_REFRESH_RESET_ALL || c == CMD_REFRESH_SET_STOP ||
			c == CMD_REFRESH_PLAIN;
	endfunction : is_cbr

	function automatic logic uses_mask(input vdc_cmd_t c);
		return c == CMD_MASKED_ARRAY_WRITE || c == CMD_MASKED_BLOCK_WRITE ||
			c == CMD_MASKED_FLASH_WRITE || c == CMD_MASKED_BUFFER_TO_ROW ||
			c == CMD_MASKED_SPLIT_BUFFER_TO_ROW;
	endfunction : uses_mask

	// Commands whose RAS fall is the only event; CAS stays high.
	function automatic logic ras_only(input vdc_cmd_t c);
		return c == CMD_ROW_ONLY_REFRESH || c == CMD_MASKED_FLASH_WRITE;
	endfunction : ras_only

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_RAS = 3'b010,
		ST_CAS = 3'b011,
		ST_PRE = 3'b100
	} vdc_state_t;

	vdc_state_t state_q, state_d;
	logic [7:0] cnt_q, cnt_d;
	vdc_req_t req_q, req_d;
	vdc_ctl_t ctl_q, ctl_d;
	logic [8:0] addr_q, addr_d;
	logic [7:0] dq_q, dq_d;
	logic [7:0] oe_q, oe_d;
	logic [7:0] rdbuf_q, rdbuf_d;
	logic mask_held_q, mask_held_d;
	logic [31:0] rdata_q, rdata_d;
	logic is_read;

	assign is_read = req_q.cmd == CMD_ARRAY_READ;

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q == 8'h00 ? 8'h00 : cnt_q - 8'h01;
		req_d = req_q;
		ctl_d = ctl_q;
		addr_d = addr_q;
		dq_d = dq_q;
		oe_d = oe_q;
		rdbuf_d = rdbuf_q;
		mask_held_d = mask_held_q;
		rdata_d = 32'h0000_0000;
		if (sw_wr && sw_addr == REG_ADDR)
		begin
			req_d.row = sw_wdata[8:0];
			req_d.col = sw_wdata[ADDR_COL_LSB +: 9];
		end
		if (sw_wr && sw_addr == REG_DATA)
		begin
			req_d.data = sw_wdata[7:0];
			req_d.mask = sw_wdata[DATA_MASK_LSB +: 8];
		end
		if (sw_rd)
		begin
			case (sw_addr)
				REG_DATA: rdata_d = {24'h00_0000, rdbuf_q};
				REG_STATUS: rdata_d = {29'h0, split_half_flag,
					mask_held_q, state_q != ST_IDLE};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
		case (state_q)
			ST_IDLE:
				if (sw_wr && sw_addr == REG_CMD)
				begin
					req_d.cmd = vdc_cmd_t'(sw_wdata[3:0]);
					// Refresh with CAS low needs CAS to fall before RAS.
					ctl_d = ras_levels(vdc_cmd_t'(sw_wdata[3:0]));
					ctl_d.ras_n = 1'b1;
					ctl_d.mask_write_enable_n = 1'b1;
					ctl_d.transfer_output_enable_n = 1'b1;
					addr_d = req_d.row;
					state_d = ST_SETUP;
					cnt_d = 8'(RAS_SETUP_CYC);
				end
			ST_SETUP:
			begin
				ctl_d = ras_levels(req_q.cmd);
				ctl_d.ras_n = 1'b1;
				// plane mask on data pins at RAS
				if (uses_mask(req_q.cmd) && !mask_held_q)
				begin
					dq_d = req_q.mask;
					oe_d = 8'hFF;
				end
				if (cnt_q == 8'h00)
				begin
					ctl_d.ras_n = 1'b0;
					state_d = ST_RAS;
					cnt_d = 8'(RAS_CAS_CYC);
					// stop code presented on the address pins
					if (req_q.cmd == CMD_REFRESH_SET_STOP)
						addr_d = req_q.row;
					if (req_q.cmd == CMD_REFRESH_RESET_ALL)
						mask_held_d = 1'b0;
				end
			end
			ST_RAS:
				if (cnt_q == 8'h00)
				begin
					oe_d = 8'h00;
					if (is_cbr(req_q.cmd) || ras_only(req_q.cmd))
					begin
						state_d = ST_CAS;
						cnt_d = 8'(CAS_LOW_CYC);
					end
					else
					begin
						// column is the tap for transfers
						addr_d = req_q.col;
						ctl_d.cas_n = 1'b0;
						ctl_d.transfer_output_enable_n = !is_read;
						ctl_d.special_function_select =
							req_q.cmd == CMD_BLOCK_WRITE ||
							req_q.cmd == CMD_MASKED_BLOCK_WRITE ||
							req_q.cmd == CMD_LOAD_FILL_COLOR;
						// write data driven on the same edge as the later fall
						if (req_q.cmd inside {CMD_ARRAY_WRITE,
							CMD_MASKED_ARRAY_WRITE, CMD_BLOCK_WRITE,
							CMD_MASKED_BLOCK_WRITE, CMD_LOAD_PLANE_MASK,
							CMD_LOAD_FILL_COLOR})
						begin
							dq_d = req_q.data;
							oe_d = 8'hFF;
						end
						// Block writes also need the write-enable fall.
						if (req_q.cmd inside {CMD_ARRAY_WRITE,
							CMD_BLOCK_WRITE})
							ctl_d.mask_write_enable_n = 1'b0;
						state_d = ST_CAS;
						cnt_d = 8'(CAS_LOW_CYC);
					end
				end
			ST_CAS:
				if (cnt_q == 8'h00)
				begin
					// sample read data late in the CAS phase
					if (is_read)
						rdbuf_d = dq_in;
					// mask register now holds the planes
					if (req_q.cmd == CMD_LOAD_PLANE_MASK)
						mask_held_d = 1'b1;
					ctl_d = '{ras_n: 1'b1, cas_n: 1'b1,
						transfer_output_enable_n: 1'b1,
						mask_write_enable_n: 1'b1,
						special_function_select: 1'b0};
					oe_d = 8'h00;
					state_d = ST_PRE;
					cnt_d = 8'(PRECHARGE_CYC);
				end
			ST_PRE:
				if (cnt_q == 8'h00)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
			req_q <= '0;
			ctl_q <= '{ras_n: 1'b1, cas_n: 1'b1,
				transfer_output_enable_n: 1'b1, mask_write_enable_n: 1'b1,
				special_function_select: 1'b0};
			addr_q <= 9'h000;
			dq_q <= 8'h00;
			oe_q <= 8'h00;
			rdbuf_q <= 8'h00;
			// device powers up in per-cycle mask mode
			mask_held_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			req_q <= req_d;
			ctl_q <= ctl_d;
			addr_q <= addr_d;
			dq_q <= dq_d;
			oe_q <= oe_d;
			rdbuf_q <= rdbuf_d;
			mask_held_q <= mask_held_d;
			rdata_q <= rdata_d;
		end
	end

	assign ctl = ctl_q;
	assign address_pins = addr_q;
	assign dq_out = dq_q;
	assign dq_oe = oe_q;
	assign sw_rdata = rdata_q;

endmodule : vdc_ctrl

// file: hdl/vdc_pkg.sv
// Package for the video DRAM cycle controller: commands, pin bundle,
// timing counts. Assumes a 200 MHz system clock.
package vdc_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	// Least strobe phase times, in picoseconds.
	localparam int T_RAS_SETUP_PS = 15000;
	localparam int T_RAS_CAS_PS = 20000;
	localparam int T_CAS_LOW_PS = 20000;
	localparam int T_PRECHARGE_PS = 60000;
	localparam int RAS_SETUP_CYC =
		(T_RAS_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RAS_CAS_CYC =
		(T_RAS_CAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CAS_LOW_CYC =
		(T_CAS_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PRECHARGE_CYC =
		(T_PRECHARGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_REFRESH_RESET_ALL = 4'h0,
		CMD_REFRESH_SET_STOP = 4'h1,
		CMD_REFRESH_PLAIN = 4'h2,
		CMD_ROW_ONLY_REFRESH = 4'h3,
		CMD_ARRAY_READ = 4'h4,
		CMD_ARRAY_WRITE = 4'h5,
		CMD_MASKED_ARRAY_WRITE = 4'h6,
		CMD_BLOCK_WRITE = 4'h7,
		CMD_MASKED_BLOCK_WRITE = 4'h8,
		CMD_MASKED_FLASH_WRITE = 4'h9,
		CMD_LOAD_PLANE_MASK = 4'hA,
		CMD_LOAD_FILL_COLOR = 4'hB,
		CMD_ROW_TO_BUFFER = 4'hC,
		CMD_SPLIT_ROW_TO_BUFFER = 4'hD,
		CMD_MASKED_BUFFER_TO_ROW = 4'hE,
		CMD_MASKED_SPLIT_BUFFER_TO_ROW = 4'hF
	} vdc_cmd_t;

	// ------------------------------------------------------------
	// Bundles
	// ------------------------------------------------------------
	// Control pin levels, all active low except the function select.
	typedef struct packed {
		logic ras_n;
		logic cas_n;
		logic transfer_output_enable_n;
		logic mask_write_enable_n;
		logic special_function_select;
	} vdc_ctl_t;

	typedef struct packed {
		vdc_cmd_t cmd;
		logic [8:0] row;
		logic [8:0] col;
		logic [7:0] mask;
		logic [7:0] data;
	} vdc_req_t;

	// Register map of the controller's own software port.
	localparam logic [2:0] REG_CMD = 3'h0;
	localparam logic [2:0] REG_ADDR = 3'h1;
	localparam logic [2:0] REG_DATA = 3'h2;
	localparam logic [2:0] REG_STATUS = 3'h3;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_MASK_HELD_BIT = 1;
	localparam int ADDR_COL_LSB = 16;
	localparam int DATA_MASK_LSB = 8;

endpackage : vdc_pkg

// file: sim/vdc_ctrl_bench.sv
// Self-checking bench for the video DRAM cycle controller.
// Assumes the DRAM model answers on the pins beside it.
`timescale 1ns/1ps
module vdc_ctrl_bench;
	import vdc_pkg::*;
	logic clock = 0, rst = 1, sw_wr = 0, sw_rd = 0;
	logic [2:0] sw_addr = 0;
	logic [31:0] sw_wdata = 0, sw_rdata, v;
	vdc_ctl_t ctl;
	logic [8:0] address_pins, r;
	logic [7:0] dq_out, dq_oe, dq_in, a, b, pm;
	logic split_half_flag;
	int failures = 0, n_checks = 0, seed = 53201;
	always #2.5 clock = ~clock;
	vdc_ctrl dut (.clock(clock), .rst(rst), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
		.sw_rdata(sw_rdata), .ctl(ctl), .address_pins(address_pins),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
		.split_half_flag(split_half_flag));
	vdc_dram_model u_dram (.clock(clock), .rst(rst), .ctl(ctl),
		.address_pins(address_pins), .dq_out(dq_out), .dq_oe(dq_oe),
		.dq_in(dq_in), .split_half_flag(split_half_flag));
	function logic [7:0] mw(input logic [7:0] o, d, m);
		return (o & ~m) | (d & m);
	endfunction : mw
	task chk(input logic [31:0] g, e);
		n_checks++;
		if (g !== e) failures++;
		if (g !== e) $display("wrong value at %0t: %h not %h", $time, g, e);
	endtask : chk
	task wr(input logic [2:0] ad, input logic [31:0] d);
		@(posedge clock);
		sw_addr <= ad;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clock);
		sw_wr <= 1'b0;
	endtask : wr
	task rd(input logic [2:0] ad);
		@(posedge clock);
		sw_addr <= ad;
		sw_rd <= 1'b1;
		@(posedge clock);
		sw_rd <= 1'b0;
		#1 v = sw_rdata;
	endtask : rd
	task cmd(input vdc_cmd_t c, input logic [8:0] w, input logic [7:0] d, k);
		wr(REG_ADDR, {7'h00, w, 7'h00, w});
		wr(REG_DATA, {16'h0, k, d});
		wr(REG_CMD, {28'h0, c});
		// Poll at least once so an old idle reading is never reused.
		v = 32'h1;
		for (int i = 0; i < 100 && v[0] !== 1'b0; i++) rd(REG_STATUS);
		chk(v[0], 1'b0);
	endtask : cmd
	task rdrow(input logic [8:0] w);
		cmd(CMD_ARRAY_READ, w, 8'h00, 8'h00);
		rd(REG_DATA);
	endtask : rdrow
	task test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		repeat (20000) @(posedge clock);
		failures++;
		test_done();
	end
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rd(REG_STATUS);
		chk(v[2:0], 3'h0);
		rd(3'h5);
		chk(v, 32'h0);
		for (int i = 1; i <= 16; i++)
			cmd(vdc_cmd_t'(i[3:0]), 9'h01F, 8'h00, 8'h00);
		rd(REG_STATUS);
		chk(v[2:0], 3'h0);
		$display("test all codes done");
		repeat (6)
		begin
			r = 9'($random(seed));
			a = 8'($random(seed));
			cmd(CMD_ARRAY_WRITE, r, a, 8'h00);
			rdrow(r);
			chk(v[7:0], a);
		end
		// A block write must not turn into a plain array write.
		cmd(CMD_BLOCK_WRITE, r, ~a, 8'h00);
		rdrow(r);
		chk(v[7:0], a);
		b = 8'($random(seed));
		pm = 8'($random(seed));
		cmd(CMD_MASKED_ARRAY_WRITE, r, b, pm);
		a = mw(a, b, pm);
		rdrow(r);
		chk(v[7:0], a);
		cmd(CMD_LOAD_PLANE_MASK, r, 8'h0F, 8'h00);
		rd(REG_STATUS);
		chk(v[1], 1'b1);
		cmd(CMD_MASKED_ARRAY_WRITE, r, ~a, 8'hF0);
		a = mw(a, ~a, 8'h0F);
		rdrow(r);
		chk(v[7:0], a);
		cmd(CMD_LOAD_FILL_COLOR, r, 8'h5A, 8'h00);
		cmd(CMD_MASKED_FLASH_WRITE, r, 8'h00, 8'hFF);
		a = mw(a, 8'h5A, 8'h0F);
		rdrow(r);
		chk(v[7:0], a);
		$display("test masks done");
		cmd(CMD_REFRESH_RESET_ALL, r, 8'h00, 8'h00);
		rd(REG_STATUS);
		chk(v[1], 1'b0);
		cmd(CMD_MASKED_ARRAY_WRITE, r, ~a, 8'hF0);
		a = mw(a, ~a, 8'hF0);
		rdrow(r);
		chk(v[7:0], a);
		wr(REG_CMD, {28'h0, CMD_REFRESH_PLAIN});
		wr(REG_CMD, {28'h0, CMD_LOAD_PLANE_MASK});
		cmd(CMD_REFRESH_PLAIN, r, 8'h00, 8'h00);
		rd(REG_STATUS);
		chk(v[1], 1'b0);
		cmd(CMD_SPLIT_ROW_TO_BUFFER, r, 8'h00, 8'h00);
		rd(REG_STATUS);
		chk(v[2], 1'b1);
		cmd(CMD_MASKED_SPLIT_BUFFER_TO_ROW, r, 8'h00, 8'h00);
		rd(REG_STATUS);
		chk(v[2], 1'b0);
		$display("test refresh and split done");
		test_done();
	end
endmodule : vdc_ctrl_bench
bind vdc_ctrl vdc_ctrl_props u_props (.clock(clock), .rst(rst),
	.sw_rd(sw_rd), .sw_rdata(sw_rdata), .ctl(ctl), .dq_oe(dq_oe));

// file: sim/vdc_ctrl_props.sv
// Port checker for the video DRAM cycle controller.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module vdc_ctrl_props
	import vdc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic sw_rd,
	input wire logic [31:0] sw_rdata,
	input wire vdc_pkg::vdc_ctl_t ctl,
	input wire logic [7:0] dq_oe
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_idle;
		disable iff (1'b0) rst |=> ctl == 5'b11110 && dq_oe == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("pins not idle in reset");
	property p_rdz;
		!sw_rd |=> sw_rdata == 32'h0;
	endproperty
	a_rdz: assert property (p_rdz) else $error("read data without read");
	property p_cbr;
		$fell(ctl.ras_n) && !ctl.cas_n |-> dq_oe == 8'h00;
	endproperty
	a_cbr: assert property (p_cbr) else $error("data driven in refresh");
	property p_wdat;
		$fell(ctl.cas_n) && !ctl.ras_n && !ctl.mask_write_enable_n
			&& ctl.transfer_output_enable_n
			&& $past(ctl.transfer_output_enable_n) |-> dq_oe == 8'hFF;
	endproperty
	a_wdat: assert property (p_wdat) else $error("write data not driven");
	property p_rddat;
		!ctl.ras_n && !ctl.cas_n && !ctl.transfer_output_enable_n
			&& ctl.mask_write_enable_n |-> dq_oe == 8'h00;
	endproperty
	a_rddat: assert property (p_rddat) else $error("bus fight in read");
	property p_load;
		$fell(ctl.ras_n) && ctl.cas_n && ctl.transfer_output_enable_n
			&& ctl.mask_write_enable_n && ctl.special_function_select
			|-> ##5 ($fell(ctl.cas_n) && dq_oe == 8'hFF);
	endproperty
	a_load: assert property (p_load) else $error("register load bad");
	property p_flash;
		$fell(ctl.ras_n) && ctl.cas_n && ctl.transfer_output_enable_n
			&& !ctl.mask_write_enable_n && ctl.special_function_select
			|-> ctl.cas_n [*8];
	endproperty
	a_flash: assert property (p_flash) else $error("column strobe in flash");
	property p_pre;
		$rose(ctl.ras_n) |-> ctl.ras_n [*8];
	endproperty
	a_pre: assert property (p_pre) else $error("precharge too short");
	c_cbr: cover property ($fell(ctl.ras_n) && !ctl.cas_n);
	c_wr: cover property ($fell(ctl.cas_n) && !ctl.mask_write_enable_n);
	c_xfer: cover property ($fell(ctl.ras_n) && !ctl.transfer_output_enable_n);
endmodule : vdc_ctrl_props

// file: sim/vdc_dram_model.sv
// Behavioural video DRAM on the controller's pins, one byte per row.
// Assumes pins change on the same clock; block writes leave data alone.
`timescale 1ns/1ps
module vdc_dram_model
	import vdc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire vdc_pkg::vdc_ctl_t ctl,
	input wire logic [8:0] address_pins,
	input wire logic [7:0] dq_out,
	input wire logic [7:0] dq_oe,
	output logic [7:0] dq_in,
	output logic split_half_flag
);
	logic [7:0] mem [0:511];
	vdc_ctl_t p, k;
	logic [8:0] row;
	logic [7:0] rm, pm, col, m, wm;
	logic pc;
	assign m = pc ? (dq_out & dq_oe) : pm;
	assign wm = k.mask_write_enable_n ? 8'hFF : rm;
	// drive only after the later fall; otherwise a changed value.
	assign dq_in = (!ctl.ras_n && !ctl.cas_n
		&& !ctl.transfer_output_enable_n) ? mem[row] : ~mem[row];
	always @(posedge clock)
	begin
		p <= ctl;
		if (rst)
		begin
			pc <= 1'b1;
			split_half_flag <= 1'b0;
			foreach (mem[i]) mem[i] <= 8'h00;
		end
		else if (p.ras_n && !ctl.ras_n)
		begin
			k <= ctl;
			row <= address_pins;
			rm <= m;
			if (!ctl.cas_n && !ctl.special_function_select) pc <= 1'b1;
			if (ctl.cas_n && !ctl.transfer_output_enable_n
				&& ctl.special_function_select)
				split_half_flag <= !split_half_flag;
			if (ctl.cas_n && ctl.transfer_output_enable_n
				&& !ctl.mask_write_enable_n && ctl.special_function_select)
				mem[address_pins] <= (mem[address_pins] & ~m) | (col & m);
		end
		else if (p.cas_n && !ctl.cas_n && !ctl.ras_n
			&& k.transfer_output_enable_n)
		begin
			if (k.special_function_select && k.mask_write_enable_n)
			begin
				if (ctl.special_function_select) col <= dq_out;
				else pm <= dq_out;
				if (!ctl.special_function_select) pc <= 1'b0;
			end
			else if (!k.special_function_select
				&& !ctl.special_function_select && !ctl.mask_write_enable_n)
				mem[row] <= (mem[row] & ~wm) | (dq_out & wm);
		end
	end
endmodule : vdc_dram_model
